// *** rtl/spr_pkg.sv ***
/*
 * Shared definitions for the serial peripheral pin router: register offsets,
 * field positions, route codes, pin group shapes and the carrier structs.
 * Assumes a single peripheral clock domain and byte-wide registers.
 */
package spr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus shape and register map.

    // Width of the register address.
    localparam int SPR_ADDR_W = 8;
    // Width of the register data.
    localparam int SPR_DATA_W = 8;
    // Offset of the asynchronous serial route register.
    localparam logic [SPR_ADDR_W-1:0] OFS_ASYNC_ROUTE = 8'h02;
    // Offset of the two-wire and synchronous serial route register.
    localparam logic [SPR_ADDR_W-1:0] OFS_TWSS_ROUTE = 8'h03;
    // Reset value of both route registers: every peripheral on its default group.
    localparam logic [SPR_DATA_W-1:0] ROUTE_RESET = 8'h00;
    // Implemented bits of the two-wire and synchronous serial register.
    localparam logic [SPR_DATA_W-1:0] TWSS_MASK = 8'h33;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and route codes.

    // Width of every route field.
    localparam int FLD_W = 2;
    // Lowest bit of the two-wire route field.
    localparam int TWI_FLD_LSB = 4;
    // Lowest bit of the synchronous serial route field.
    localparam int SPI_FLD_LSB = 0;
    // Route codes shared by every field.
    localparam logic [1:0] CODE_DEFAULT = 2'h0;
    localparam logic [1:0] CODE_ALT_ONE = 2'h1;
    localparam logic [1:0] CODE_ALT_TWO = 2'h2;
    localparam logic [1:0] CODE_NONE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Ports, peripherals and pin group shapes.

    // Number of pin ports handled and pins per port.
    localparam int N_PORT = 5;
    localparam int PORT_W = 8;
    // Port indices.
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_E = 3'h3;
    localparam logic [2:0] PORT_F = 3'h4;
    // Peripheral indices: four asynchronous serial, synchronous serial, two-wire.
    localparam int N_SERIAL = 4;
    localparam int N_PERIPH = 6;
    localparam logic [2:0] PER_SPI = 3'h4;
    localparam logic [2:0] PER_TWI = 3'h5;
    // Placement slots: one per serial, one for the synchronous serial, two for two-wire.
    localparam int N_SLOT = 7;
    // Signals carried per peripheral.
    localparam int SIG_W = 4;
    // First pin of the low, two-wire and high groups.
    localparam logic [2:0] BASE_LO = 3'h0;
    localparam logic [2:0] BASE_TWI = 3'h2;
    localparam logic [2:0] BASE_HI = 3'h4;
    // Pin counts of the group shapes.
    localparam logic [2:0] CNT_FULL = 3'h4;
    localparam logic [2:0] CNT_TRIPLE = 3'h3;
    localparam logic [2:0] CNT_PAIR = 3'h2;
    // Signal offset of the two-wire client lines inside the two-wire link.
    localparam logic [1:0] OFF_HOST = 2'h0;
    localparam logic [1:0] OFF_CLIENT = 2'h2;

    // Output value and drive request of one peripheral, signal 0 first.
    typedef struct packed {
        logic [SIG_W-1:0] dout;
        logic [SIG_W-1:0] den;
    } spr_link_s;

    // Where one slot of a peripheral lands on the pins.
    typedef struct packed {
        logic en;
        logic [2:0] periph;
        logic [2:0] port;
        logic [2:0] base;
        logic [2:0] cnt;
        logic [1:0] off;
    } spr_place_s;

endpackage : spr_pkg

// *** rtl/spr_sync.sv ***
/*
 * Two-stage synchroniser for a bus of independent pin levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps
module spr_sync #(
    parameter int W = 40
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second stage.
    logic [W-1:0] meta;
    // Next values of both stages.
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // Shift the pin levels one stage along; reset clears both stages.
    always_comb begin
        next_meta = nrst ? d : '0;
        next_q = nrst ? meta : '0;
    end

    // Register both stages.
    always_ff @(posedge sys_clk) begin
        meta <= next_meta;
        q <= next_q;
    end

endmodule : spr_sync

// *** rtl/spr_pin_router.sv ***
/*
 * Serial peripheral pin router: two byte registers pick which port pin group
 * each asynchronous serial, two-wire and synchronous serial peripheral uses.
 * Assumes peripheral links come from logic on sys_clk and pad inputs are raw
 * pin levels from outside that domain.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - Serial 2: F[3:0], F[6:4], or none.
// - Serial 1: C[3:0], C[7:4], or none.
// - Serial 0: A[3:0], A[7:4], or none.
// - Serial fields at bits 5:4, 3:2, 1:0.
// - Two-wire/sync register offset 0x03, resets zero.
// - Two-wire lines on A[3:2] or C[3:2].
// - Dual mode client on C[3:2] or F[3:2].
// - Sync serial: A[7:4], C[3:0], E[3:0], none.
// - Serial register offset 0x02, serial 3 bits 7:6.
module spr_pin_router (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [spr_pkg::SPR_ADDR_W-1:0] reg_addr,
    input wire logic [spr_pkg::SPR_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spr_pkg::SPR_DATA_W-1:0] reg_rdata,
    input wire spr_pkg::spr_link_s [spr_pkg::N_SERIAL-1:0] serial_link,
    input wire spr_pkg::spr_link_s sync_serial_link,
    input wire spr_pkg::spr_link_s twowire_link,
    input wire logic twowire_dual,
    output logic [spr_pkg::N_SERIAL-1:0][spr_pkg::SIG_W-1:0] serial_in,
    output logic [spr_pkg::SIG_W-1:0] sync_serial_in,
    output logic [spr_pkg::SIG_W-1:0] twowire_in,
    input wire logic [spr_pkg::N_PORT-1:0][spr_pkg::PORT_W-1:0] pad_in,
    output logic [spr_pkg::N_PORT-1:0][spr_pkg::PORT_W-1:0] pad_out,
    output logic [spr_pkg::N_PORT-1:0][spr_pkg::PORT_W-1:0] pad_oe_n
);
    import spr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    // Serial route register, one two-bit field per serial controller.
    logic [SPR_DATA_W-1:0] async_serial_route;
    // Two-wire and synchronous serial route register.
    logic [SPR_DATA_W-1:0] twowire_sync_serial_route;
    // Read data register; holds zero except after a read strobe.
    logic [SPR_DATA_W-1:0] rdata;
    logic [SPR_DATA_W-1:0] next_async;
    logic [SPR_DATA_W-1:0] next_twss;
    logic [SPR_DATA_W-1:0] next_rdata;
    // Decoded route fields.
    logic [N_SERIAL-1:0][FLD_W-1:0] serial_sel;
    logic [FLD_W-1:0] twowire_route_sel;
    logic [FLD_W-1:0] sync_serial_route_sel;

    // Fields sit side by side, serial 0 in the lowest bits.
    // field layout
    assign serial_sel = async_serial_route;
    assign twowire_route_sel = twowire_sync_serial_route[TWI_FLD_LSB +: FLD_W];
    assign sync_serial_route_sel = twowire_sync_serial_route[SPI_FLD_LSB +: FLD_W];

    // Decode writes and reads; unmapped addresses read zero and ignore writes.
    always_comb begin
        next_async = async_serial_route;
        next_twss = twowire_sync_serial_route;
        next_rdata = '0;
        if (!nrst) begin
            next_async = ROUTE_RESET;
            next_twss = ROUTE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == OFS_ASYNC_ROUTE) begin
                next_async = reg_wdata;
            end
            if (reg_addr == OFS_TWSS_ROUTE) begin
                next_twss = reg_wdata & TWSS_MASK;
            end
        end else if (reg_rd) begin
            // Reserved bits of the two-wire register are never stored, so they read zero.
            case (reg_addr)
                OFS_ASYNC_ROUTE: begin
                    next_rdata = async_serial_route;
                end
                OFS_TWSS_ROUTE: begin
                    next_rdata = twowire_sync_serial_route;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // Register the route fields and the read answer.
    always_ff @(posedge sys_clk) begin
        async_serial_route <= next_async;
        twowire_sync_serial_route <= next_twss;
        rdata <= next_rdata;
    end

    assign reg_rdata = rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisation.

    // Pad levels after two flops; only these feed the routing.
    logic [N_PORT-1:0][PORT_W-1:0] pad_sync;

    // The pins are outside the clock domain, so each level passes two flops.
    spr_sync #(
        .W(N_PORT * PORT_W)
    ) u_pad_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d(pad_in),
        .q(pad_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Placement decode.

    // Serial controller placement from its index and route code.
    function automatic spr_place_s serial_place(input logic [1:0] idx, input logic [1:0] code);
        spr_place_s p;
        p = '0;
        p.periph = {1'b0, idx};
        p.off = OFF_HOST;
        p.en = (code == CODE_DEFAULT) || (code == CODE_ALT_ONE);
        p.base = (code == CODE_ALT_ONE) ? BASE_HI : BASE_LO;
        p.cnt = CNT_FULL;
        case (idx)
            2'h0: begin
                p.port = PORT_A;
            end
            2'h1: begin
                p.port = PORT_C;
            end
            2'h2: begin
                p.port = PORT_F;
                p.cnt = (code == CODE_ALT_ONE) ? CNT_TRIPLE : CNT_FULL;
            end
            default: begin
                p.port = PORT_B;
                p.cnt = (code == CODE_ALT_ONE) ? CNT_PAIR : CNT_FULL;
            end
        endcase
        return p;
    endfunction : serial_place

    // Slots in rising priority; a later slot wins a pin claimed twice.
    spr_place_s [N_SLOT-1:0] place;

    // Build every slot from the route fields.
    always_comb begin
        place = '0;
        for (int i = 0; i < N_SERIAL; i++) begin
            place[N_SERIAL-1-i] = serial_place(2'(N_SERIAL-1-i), serial_sel[N_SERIAL-1-i]);
        end
        place[4].periph = PER_SPI;
        place[4].cnt = CNT_FULL;
        place[4].en = (sync_serial_route_sel != CODE_NONE);
        case (sync_serial_route_sel)
            CODE_DEFAULT: begin
                place[4].port = PORT_A;
                place[4].base = BASE_HI;
            end
            CODE_ALT_ONE: begin
                place[4].port = PORT_C;
                place[4].base = BASE_LO;
            end
            default: begin
                place[4].port = PORT_E;
                place[4].base = BASE_LO;
            end
        endcase
        place[5].periph = PER_TWI;
        place[5].off = OFF_CLIENT;
        place[5].cnt = CNT_PAIR;
        place[5].base = BASE_TWI;
        place[5].en = twowire_dual && (twowire_route_sel != CODE_NONE);
        place[5].port = (twowire_route_sel == CODE_DEFAULT) ? PORT_C : PORT_F;
        place[6].periph = PER_TWI;
        place[6].off = OFF_HOST;
        place[6].cnt = CNT_PAIR;
        place[6].base = BASE_TWI;
        place[6].en = (twowire_route_sel != CODE_NONE);
        place[6].port = (twowire_route_sel == CODE_ALT_TWO) ? PORT_C : PORT_A;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing between peripherals and pins.

    // All peripheral links as one array, indexed by peripheral number.
    spr_link_s [N_PERIPH-1:0] link;
    assign link = {twowire_link, sync_serial_link, serial_link};

    // Registered pin drive and returned pin levels.
    logic [N_PORT-1:0][PORT_W-1:0] next_pad_out;
    logic [N_PORT-1:0][PORT_W-1:0] next_pad_oe_n;
    logic [N_PERIPH-1:0][SIG_W-1:0] back;
    logic [N_PERIPH-1:0][SIG_W-1:0] next_back;

    // Walk every slot and signal; pins nobody claims stay undriven.
    always_comb begin
        logic [2:0] pin;
        logic [1:0] sig;
        pin = '0;
        sig = '0;
        next_pad_out = '0;
        next_pad_oe_n = '1;
        next_back = '0;
        if (nrst) begin
            for (int s = 0; s < N_SLOT; s++) begin
                for (int k = 0; k < SIG_W; k++) begin
                    if (place[s].en && (3'(k) < place[s].cnt)) begin
                        pin = place[s].base + 3'(k);
                        sig = place[s].off + 2'(k);
                        next_pad_out[place[s].port][pin] = link[place[s].periph].dout[sig];
                        next_pad_oe_n[place[s].port][pin] = ~link[place[s].periph].den[sig];
                        next_back[place[s].periph][sig] = pad_sync[place[s].port][pin];
                    end
                end
            end
        end
    end

    // One flop stage so every output leaves from a register, glitch free.
    always_ff @(posedge sys_clk) begin
        pad_out <= next_pad_out;
        pad_oe_n <= next_pad_oe_n;
        back <= next_back;
    end

    assign serial_in = back[N_SERIAL-1:0];
    assign sync_serial_in = back[PER_SPI];
    assign twowire_in = back[PER_TWI];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_serial3_alt_pair: assert property (
        serial_sel[3] == CODE_ALT_ONE |-> place[3].en && place[3].port == PORT_B && place[3].cnt == CNT_PAIR
    ) else $error("serial 3 alternate group wrong");
    a_serial2_alt_three: assert property (
        serial_sel[2] == CODE_ALT_ONE |-> place[2].port == PORT_F && place[2].base == BASE_HI && place[2].cnt == CNT_TRIPLE
    ) else $error("serial 2 alternate group wrong");
    a_serial1_groups: assert property (
        serial_sel[1] == CODE_DEFAULT |-> place[1].en && place[1].port == PORT_C && place[1].base == BASE_LO
    ) else $error("serial 1 default group wrong");
    a_serial0_drive: assert property (
        serial_sel[0] == CODE_DEFAULT && twowire_route_sel == CODE_NONE && sync_serial_route_sel != CODE_ALT_ONE
        |=> pad_oe_n[PORT_A][3:0] == ~$past(serial_link[0].den) && pad_out[PORT_A][3:0] == $past(serial_link[0].dout)
    ) else $error("serial 0 not driving port A low pins");
    a_field_write: assert property (
        reg_wr && reg_addr == OFS_ASYNC_ROUTE |=> serial_sel[2] == $past(reg_wdata[5:4]) && serial_sel[0] == $past(reg_wdata[1:0])
    ) else $error("serial route field not stored");
    a_reset_default: assert property (
        $rose(nrst) |-> async_serial_route == ROUTE_RESET && twowire_sync_serial_route == ROUTE_RESET
    ) else $error("route registers not cleared by reset");
    a_twowire_main: assert property (
        twowire_route_sel == CODE_ALT_TWO |=> pad_out[PORT_C][3:2] == $past(twowire_link.dout[1:0])
    ) else $error("two-wire lines not on port C");
    a_twowire_client: assert property (
        twowire_dual && twowire_route_sel == CODE_ALT_ONE |=> twowire_in[3:2] == $past(pad_sync[PORT_F][3:2])
    ) else $error("two-wire client not on port F");
    a_sync_serial_e: assert property (
        sync_serial_route_sel == CODE_ALT_TWO |=> sync_serial_in == $past(pad_sync[PORT_E][3:0])
    ) else $error("sync serial not on port E");
    a_read_back: assert property (
        reg_rd && !reg_wr && reg_addr == OFS_ASYNC_ROUTE |=> reg_rdata == $past(async_serial_route) ##1 reg_rdata == '0 || $past(reg_rd)
    ) else $error("serial route read back wrong");
    a_reserved_detach: assert property (
        serial_sel[3] == CODE_ALT_TWO |=> serial_in[3] == '0
    ) else $error("reserved code left serial 3 connected");
    a_unselected_quiet: assert property (
        serial_sel[1] == CODE_NONE && sync_serial_route_sel != CODE_ALT_ONE && twowire_route_sel != CODE_ALT_TWO
        && !(twowire_dual && twowire_route_sel == CODE_DEFAULT) |=> pad_oe_n[PORT_C] == '1
    ) else $error("port C driven with nothing routed");

    c_serial3_alt: cover property (serial_sel[3] == CODE_ALT_ONE);
    c_sync_serial_c: cover property (sync_serial_route_sel == CODE_ALT_ONE);
    c_dual_client_f: cover property (twowire_dual && twowire_route_sel == CODE_ALT_TWO);
    c_route_read: cover property (reg_rd && reg_addr == OFS_TWSS_ROUTE);

endmodule : spr_pin_router

// *** bench/spr_periph_model.sv ***
/*
 * Stand-in for the serial peripherals that sit behind the pin router.
 * Assumes the bench steps the flip input by non-blocking assignment at a clock edge.
 */
`timescale 1ns/100ps
module spr_periph_model (
    input wire logic flip,
    output spr_pkg::spr_link_s [spr_pkg::N_SERIAL-1:0] serial_link,
    output spr_pkg::spr_link_s sync_serial_link,
    output spr_pkg::spr_link_s twowire_link
);
    import spr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Each peripheral owns a distinct level pattern, so a misrouted group shows.
    localparam logic [3:0] SER_PAT [4] = '{4'h5, 4'h6, 4'h3, 4'h9};
    // Mixed drive requests, so a pin that ignores its own request shows.
    localparam logic [3:0] SER_EN [4] = '{4'hE, 4'hB, 4'h7, 4'hD};

    // sets dout on every line, whatever its den bit.
    // Some lines ask to drive and some do not; flip inverts the values to prove the pins follow.
    always_comb begin
        for (int n = 0; n < N_SERIAL; n++) begin
            serial_link[n].dout = SER_PAT[n] ^ {SIG_W{flip}};
            serial_link[n].den = SER_EN[n];
        end
        sync_serial_link.dout = 4'hC ^ {SIG_W{flip}};
        sync_serial_link.den = 4'hD;
        twowire_link.dout = 4'hB ^ {SIG_W{flip}};
        twowire_link.den = 4'h7;
    end

endmodule : spr_periph_model

// *** bench/spr_pin_router_test.sv ***
/*
 * Self-checking bench for the serial peripheral pin router.
 * Assumes the router answers reads one cycle late and the pads settle within three edges.
 */
`timescale 1ns/100ps
module spr_pin_router_test;
    import spr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Stimulus rows: both route bytes, dual mode and link inversion.
    typedef struct packed {
        logic [7:0] r2;
        logic [7:0] r3;
        logic dual;
        logic flip;
    } spr_row_s;
    localparam spr_row_s ROWS [8] = '{
        '{8'h00, 8'h00, 1'b0, 1'b0}, '{8'h55, 8'hD1, 1'b1, 1'b1}, '{8'hAA, 8'h22, 1'b1, 1'b0},
        '{8'hFC, 8'h33, 1'b1, 1'b1}, '{8'h1B, 8'h01, 1'b0, 1'b0}, '{8'hE4, 8'h12, 1'b1, 1'b1},
        '{8'h00, 8'h0C, 1'b1, 1'b1}, '{8'h55, 8'h02, 1'b0, 1'b0}};
    // Pad levels per port, A B C E F; unequal so a wrong port is caught.
    localparam logic [7:0] PADV [5] = '{8'h5A, 8'hC3, 8'h96, 8'h3C, 8'hE1};
    // Default port and alternate pin count of each serial controller.
    localparam int SPORT [4] = '{0, 2, 4, 1};
    localparam int SCNT [4] = '{4, 4, 3, 2};

    logic sys_clk;
    logic nrst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    spr_link_s [N_SERIAL-1:0] serial_link;
    spr_link_s sync_serial_link;
    spr_link_s twowire_link;
    logic twowire_dual;
    logic flip;
    logic [N_SERIAL-1:0][SIG_W-1:0] serial_in;
    logic [SIG_W-1:0] sync_serial_in;
    logic [SIG_W-1:0] twowire_in;
    logic [N_PORT-1:0][PORT_W-1:0] pad_in;
    logic [N_PORT-1:0][PORT_W-1:0] pad_out;
    logic [N_PORT-1:0][PORT_W-1:0] pad_oe_n;
    // Expected pin and returned levels.
    logic [4:0][7:0] e_out;
    logic [4:0][7:0] e_oen;
    logic [3:0][3:0] e_ser;
    logic [3:0] e_sync;
    logic [3:0] e_tw;
    int errors = 0;
    int checked = 0;

    spr_pin_router spr_pin_router_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_link(serial_link), .sync_serial_link(sync_serial_link), .twowire_link(twowire_link),
        .twowire_dual(twowire_dual), .serial_in(serial_in), .sync_serial_in(sync_serial_in),
        .twowire_in(twowire_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n));

    spr_periph_model spr_periph_model_inst (.flip(flip), .serial_link(serial_link),
        .sync_serial_link(sync_serial_link), .twowire_link(twowire_link));

    // The clock runs at 100 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reporting.
    task automatic summarize;
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t pin levels %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    ////////////////////////////////////////////////////////////////////////////
    // Register bus: one call is one cycle, so strobes may follow with no gap.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
    endtask : bus

    // Read data are sampled for the cycle after the strobe, then must fall to zero.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk_reg(reg_rdata, e);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk_reg(reg_rdata, 8'h00);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////
    // Expectation: claims applied from lowest to highest priority, last one wins.
    task automatic put(input int p, input int b, input int k, input int o, input spr_link_s l,
                       output logic [3:0] rin);
        rin = 4'h0;
        for (int i = 0; i < k; i++) begin
            e_out[p][b+i] = l.dout[o+i];
            e_oen[p][b+i] = ~l.den[o+i];
            rin[o+i] = PADV[p][b+i];
        end
    endtask : put

    task automatic check_pins(input logic [7:0] r2, input logic [7:0] r3, input logic dual);
        logic [1:0] c;
        logic [3:0] cl;
        e_out = '0;
        e_oen = '1;
        e_ser = '0;
        e_sync = 4'h0;
        e_tw = 4'h0;
        cl = 4'h0;
        for (int n = 3; n >= 0; n--) begin
            c = r2[2*n+:2];
            // Reserved and none codes claim nothing.
            if (c == CODE_DEFAULT) begin
                put(SPORT[n], 0, 4, 0, serial_link[n], e_ser[n]);
            end else if (c == CODE_ALT_ONE) begin
                put(SPORT[n], 4, SCNT[n], 0, serial_link[n], e_ser[n]);
            end
        end
        c = r3[1:0];
        if (c != CODE_NONE) begin
            put((c == CODE_DEFAULT) ? 0 : (c == CODE_ALT_ONE) ? 2 : 3, (c == CODE_DEFAULT) ? 4 : 0, 4, 0,
                sync_serial_link, e_sync);
        end
        c = r3[5:4];
        if (dual && c != CODE_NONE) begin
            put((c == CODE_DEFAULT) ? 2 : 4, 2, 2, 2, twowire_link, cl);
        end
        if (c != CODE_NONE) begin
            put((c == CODE_ALT_TWO) ? 2 : 0, 2, 2, 0, twowire_link, e_tw);
        end
        e_tw = e_tw | cl;
        for (int p = 0; p < N_PORT; p++) begin
            chk_pin(pad_out[p], e_out[p]);
            chk_pin(pad_oe_n[p], e_oen[p]);
        end
        for (int n = 0; n < N_SERIAL; n++) begin
            chk_pin({4'h0, serial_in[n]}, {4'h0, e_ser[n]});
        end
        chk_pin({4'h0, sync_serial_in}, {4'h0, e_sync});
        chk_pin({4'h0, twowire_in}, {4'h0, e_tw});
    endtask : check_pins

    ////////////////////////////////////////////////////////////////////////////
    // A hang is cut short after 10,000 cycles.
    initial begin
        #100000;
        errors++;
        summarize();
    end

    initial begin
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        twowire_dual = 1'b0;
        flip = 1'b0;
        for (int p = 0; p < N_PORT; p++) begin
            pad_in[p] = PADV[p];
        end
        repeat (10) @(posedge sys_clk);
        // Nothing is driven while reset is held.
        for (int p = 0; p < N_PORT; p++) begin
            chk_pin(pad_oe_n[p], 8'hFF);
            chk_pin(pad_out[p], 8'h00);
        end
        nrst <= 1'b1;
        rd_chk(OFS_ASYNC_ROUTE, 8'h00);
        rd_chk(OFS_TWSS_ROUTE, 8'h00);
        check_pins(8'h00, 8'h00, 1'b0);
        // Each row: back-to-back writes, readback right after, then the pins.
        for (int i = 0; i < 8; i++) begin
            flip <= ROWS[i].flip;
            twowire_dual <= ROWS[i].dual;
            bus(1'b1, 1'b0, OFS_ASYNC_ROUTE, ROWS[i].r2);
            bus(1'b1, 1'b0, OFS_TWSS_ROUTE, ROWS[i].r3);
            rd_chk(OFS_ASYNC_ROUTE, ROWS[i].r2);
            rd_chk(OFS_TWSS_ROUTE, ROWS[i].r3 & TWSS_MASK);
            check_pins(ROWS[i].r2, ROWS[i].r3, ROWS[i].dual);
        end
        // An unmapped write must leave both route bytes alone.
        bus(1'b1, 1'b0, 8'h07, 8'hFF);
        rd_chk(8'h07, 8'h00);
        rd_chk(OFS_ASYNC_ROUTE, ROWS[7].r2);
        rd_chk(OFS_TWSS_ROUTE, ROWS[7].r3);
        // A reset in mid-run returns every peripheral to its default group.
        bus(1'b1, 1'b0, OFS_TWSS_ROUTE, 8'hFF);
        nrst <= 1'b0;
        // The write strobe drops with reset, so it stays one cycle long.
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        @(posedge sys_clk);
        for (int p = 0; p < N_PORT; p++) begin
            chk_pin(pad_oe_n[p], 8'hFF);
        end
        chk_pin({4'h0, serial_in[0]}, 8'h00);
        nrst <= 1'b1;
        rd_chk(OFS_ASYNC_ROUTE, 8'h00);
        rd_chk(OFS_TWSS_ROUTE, 8'h00);
        check_pins(8'h00, 8'h00, ROWS[7].dual);
        // Pin levels take two sync flops and the output flop to reach a peripheral.
        pad_in[PORT_A] <= ~PADV[0];
        repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk_pin({4'h0, sync_serial_in}, {4'h0, PADV[0][7:4]});
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk_pin({4'h0, sync_serial_in}, {4'h0, ~PADV[0][7:4]});
        chk_pin({4'h0, serial_in[0]}, {4'h0, ~PADV[0][3:0]});
        summarize();
    end

endmodule : spr_pin_router_test
